// ===== sdram_model.sv
// Behavioural SDRAM partner that logs commands, counting refreshes per chip-select array
`timescale 1ns/1ns
module sdram_model
   import sdram_refresh_pkg::*;
#(
   parameter int NUM_CS = 2
)(
   input  wire logic              mclk,
   input  wire logic [NUM_CS-1:0] cs_n,
   input  wire logic              ras_n,
   input  wire logic              cas_n,
   input  wire logic              we_n,
   input  wire logic              cke,
   input  wire logic              precharge_all,
   output int                     pre_cnt,
   output int                     ref_cnt [NUM_CS],
   output int                     sr_cnt,
   output int                     pd_cnt,
   output int                     pre_gap,
   output int                     ref_gap
);
   // ------------------------------------------------------------
   // Command decode and logging
   // ------------------------------------------------------------
   int         cyc      = 0;
   int         last_cyc = 0;
   logic       last_pre = 1'b0;
   logic       last_ref = 1'b0;
   logic       cke_d    = 1'b1;
   logic [2:0] cmd;
   logic       sel;
   assign cmd = {ras_n, cas_n, we_n};
   assign sel = cke && (cs_n != '1);
   initial begin
      pre_cnt = 0;
      sr_cnt = 0;
      pd_cnt = 0;
      pre_gap = 0;
      ref_gap = 0;
      foreach (ref_cnt[i]) ref_cnt[i] = 0;
   end
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      cke_d <= cke;
      last_ref <= sel && (cmd == CMD_REF);
      // A clock enable fall after a refresh command means self-refresh
      if (cke_d && !cke) begin
         if (last_ref) begin
            sr_cnt <= sr_cnt + 1;
         end else begin
            pd_cnt <= pd_cnt + 1;
         end
      end
      if (sel && cmd == CMD_PRE && precharge_all) begin
         pre_cnt <= pre_cnt + 1;
         last_pre <= 1'b1;
         last_cyc <= cyc;
      end
      if (sel && cmd == CMD_REF) begin
         for (int i = 0; i < NUM_CS; i++) begin
            if (!cs_n[i]) begin
               ref_cnt[i] <= ref_cnt[i] + 1;
            end
         end
         // Gaps are kept so the bench can judge precharge and cycle spacing
         if (last_pre) begin
            pre_gap <= cyc - last_cyc;
         end else begin
            ref_gap <= cyc - last_cyc;
         end
         last_pre <= 1'b0;
         last_cyc <= cyc;
      end
   end
endmodule

// ===== sdram_refresh_map.sv
// SDRAM refresh scheduler, low-power entry and bank address mapping
//
// Contract
// - Upper row address bits pass unmultiplexed on the A21 to A25 lines.
// - Linear mode puts five linear bank bits on A15 down to A11.
// - Interleaved mode puts four interleaved bank bits on A19 to A16.
// - Page bytes equal two to column bits times width over eight.
// - Each array gets 0, 1, 2 or 4 auto-refreshes per tick.
// - Every chip-select array keeps its own refresh rate setting.
// - Hardware reset clears all rates, so refresh starts disabled.
// - Every rising edge of the refresh clock sets a pending request.
// - Pending refresh takes memory after current bus cycle, then precharges all.
// - After precharge-all, wait row precharge delay before first refresh.
// - Further refreshes follow at row-cycle spacing until count is run.
// - Bursts already running complete before the refresh sequence starts.
// - SDRAM accesses queued behind the refresh stall until it completes.
// - Refresh uses no pin shared with other memories or peripherals.
// - Refresh enabled: system reset or low power puts memory in self-refresh.
// - Refresh disabled: those same conditions give powerdown instead.
// - Controller reset disables self-refresh until a non-zero rate is set.
// - Once enabled, system reset alone triggers self-refresh.
// - Self-refresh entry is precharge-all, self-refresh command, then clock enable low.
`timescale 1ns/1ns
module sdram_refresh_map
   import sdram_refresh_pkg::*;
#(
   parameter int NUM_CS = 2
)(
   input  wire logic                  mclk,
   input  wire logic                  reset,
   input  wire logic                  refresh_clk,
   input  wire logic                  sys_reset_in,
   input  wire logic                  low_power_req,
   input  wire logic                  bus_busy,
   input  wire logic                  rate_wr,
   input  wire logic [$clog2((NUM_CS > 1) ? NUM_CS : 2)-1:0] rate_sel,
   input  wire logic [RATE_W-1:0]     refresh_rate_field,
   input  wire logic [WAIT_W-1:0]     rp_cycles,
   input  wire logic [WAIT_W-1:0]     rc_cycles,
   input  wire logic                  interleave_mode,
   input  wire logic [ADDR_W-1:0]     bus_addr,
   input  wire logic [LBA_W-1:0]      linear_bank_address,
   input  wire logic [IBA_W-1:0]      interleaved_bank_address,
   input  wire logic [COL_W-1:0]      col_bits,
   input  wire logic [MWID_W-1:0]     mem_width_bits,
   output logic [ADDR_W-1:0]          addr_out,
   output logic [PAGE_W-1:0]          page_size,
   output logic                       muxed_address_bit_11,
   output logic                       ras_n,
   output logic                       cas_n,
   output logic                       we_n,
   output logic [NUM_CS-1:0]          cs_n,
   output logic                       cke,
   output logic                       sdram_stall,
   output logic                       mem_owned,
   output logic                       refresh_enabled,
   output logic                       low_power_done
);
   localparam int SEL_W = $clog2((NUM_CS > 1) ? NUM_CS : 2);
   typedef enum logic [3:0] {
      ST_IDLE, ST_WAIT_BUS, ST_PRE, ST_WAIT_RP, ST_REF, ST_WAIT_RC,
      ST_LP_BUS, ST_LP_PRE, ST_LP_RP, ST_LP_ENTER, ST_LP_HOLD, ST_LP_EXIT
   } state_t;

   // ------------------------------------------------------------
   // Refresh clock domain
   // ------------------------------------------------------------
   // A toggle carries each tick across; the 32 kHz edge is far
   // slower than mclk, so no tick can be lost in the crossing.
   logic tick_tgl_reg;
   always_ff @(posedge refresh_clk or posedge reset) begin
      if (reset) tick_tgl_reg <= 1'b0;
      else       tick_tgl_reg <= ~tick_tgl_reg;
   end

   // ------------------------------------------------------------
   // Synchronisers
   // ------------------------------------------------------------
   logic tgl_s1_reg, tgl_s2_reg, tgl_s3_reg;
   logic srst_s1_reg, srst_s2_reg;
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         tgl_s1_reg  <= 1'b0;
         tgl_s2_reg  <= 1'b0;
         tgl_s3_reg  <= 1'b0;
         srst_s1_reg <= 1'b0;
         srst_s2_reg <= 1'b0;
      end else begin
         tgl_s1_reg  <= tick_tgl_reg;
         tgl_s2_reg  <= tgl_s1_reg;
         tgl_s3_reg  <= tgl_s2_reg;
         srst_s1_reg <= sys_reset_in;
         srst_s2_reg <= srst_s1_reg;
      end
   end
   wire tick    = tgl_s2_reg ^ tgl_s3_reg;
   wire lp_cond = srst_s2_reg | low_power_req;

   // ------------------------------------------------------------
   // Per-array rate and remaining refresh count
   // ------------------------------------------------------------
   state_t                state_reg, state_next;
   logic [NUM_CS-1:0]     rate_nz;
   logic [NUM_CS-1:0]     rem_nz;
   logic [CNT_W-1:0]      rem_reg [NUM_CS];
   logic [RATE_W-1:0]     rate_reg [NUM_CS];

   for (genvar i = 0; i < NUM_CS; i++) begin : g_cs
      logic [CNT_W-1:0] cyc;
      assign cyc = (rate_reg[i] == RATE_OFF) ? CNT_ZERO :
                   (rate_reg[i] == RATE_ONE) ? CNT_ONE  :
                   (rate_reg[i] == RATE_TWO) ? CNT_TWO  : CNT_FOUR;
      assign rate_nz[i] = rate_reg[i] != RATE_OFF;
      assign rem_nz[i]  = rem_reg[i] != CNT_ZERO;
      // independent rate per array; cleared by reset
      always_ff @(posedge mclk or posedge reset) begin
         if (reset)
            rate_reg[i] <= RATE_OFF;
         else if (rate_wr && rate_sel == SEL_W'(i))
            rate_reg[i] <= refresh_rate_field;
      end
      // count loaded per tick and run down per refresh
      always_ff @(posedge mclk or posedge reset) begin
         if (reset)
            rem_reg[i] <= CNT_ZERO;
         else if (state_reg == ST_PRE)
            rem_reg[i] <= cyc;
         else if (state_reg == ST_REF && rem_nz[i])
            rem_reg[i] <= rem_reg[i] - CNT_ONE;
      end
   end

   assign refresh_enabled = |rate_nz;

   // ------------------------------------------------------------
   // Pending request
   // ------------------------------------------------------------
   logic pend_reg;
   wire  pend_clr = (state_reg == ST_PRE);
   // tick sets pending, set wins over clear
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) pend_reg <= 1'b0;
      else       pend_reg <= tick | (pend_reg & ~pend_clr);
   end

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   logic [WAIT_W-1:0] wait_reg, wait_next;
   logic              sr_mode_reg, sr_mode_next;
   logic [CMD_W-1:0]  cmd_reg, cmd_next;
   logic [NUM_CS-1:0] csel_reg, csel_next;
   logic              ap_reg, ap_next;
   logic              cke_reg, cke_next;
   wire               wait_done = wait_reg == '0;
   wire [WAIT_W-1:0]  wait_dec  = wait_reg - WAIT_W'(1);
   always_comb begin
      state_next   = state_reg;
      wait_next    = wait_done ? wait_reg : wait_dec;
      sr_mode_next = sr_mode_reg;
      cmd_next     = CMD_NOP;
      csel_next    = '0;
      ap_next      = 1'b0;
      cke_next     = cke_reg;
      unique case (state_reg)
         ST_IDLE: begin
            if (lp_cond)
               state_next = ST_LP_BUS;
            else if (pend_reg && refresh_enabled)
               state_next = ST_WAIT_BUS;
         end
         ST_WAIT_BUS: begin
            if (!bus_busy)
               state_next = ST_PRE;
         end
         ST_PRE: begin
            cmd_next   = CMD_PRE;
            ap_next    = 1'b1;
            csel_next  = rate_nz;
            wait_next  = rp_cycles;
            state_next = ST_WAIT_RP;
         end
         ST_WAIT_RP: begin
            if (wait_done)
               state_next = ST_REF;
         end
         // one refresh per array still owing
         ST_REF: begin
            cmd_next   = CMD_REF;
            csel_next  = rem_nz;
            wait_next  = rc_cycles;
            state_next = ST_WAIT_RC;
         end
         // row cycle spacing until counts run out
         ST_WAIT_RC: begin
            if (wait_done)
               state_next = (|rem_nz) ? ST_REF : ST_IDLE;
         end
         ST_LP_BUS: begin
            sr_mode_next = refresh_enabled;
            if (!lp_cond)
               state_next = ST_IDLE;
            else if (!bus_busy)
               state_next = ST_LP_PRE;
         end
         // pages closed before clock enable drops
         ST_LP_PRE: begin
            cmd_next   = CMD_PRE;
            ap_next    = 1'b1;
            csel_next  = '1;
            wait_next  = rp_cycles;
            state_next = ST_LP_RP;
         end
         ST_LP_RP: begin
            if (wait_done)
               state_next = ST_LP_ENTER;
         end
         ST_LP_ENTER: begin
            if (sr_mode_reg) begin
               cmd_next  = CMD_REF;
               csel_next = '1;
            end
            state_next = ST_LP_HOLD;
         end
         // clock enable low after the command
         ST_LP_HOLD: begin
            cke_next = 1'b0;
            if (!lp_cond) begin
               cke_next   = 1'b1;
               wait_next  = rc_cycles;
               state_next = ST_LP_EXIT;
            end
         end
         ST_LP_EXIT: begin
            if (wait_done)
               state_next = ST_IDLE;
         end
         default: state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         state_reg   <= ST_IDLE;
         wait_reg    <= '0;
         sr_mode_reg <= 1'b0;
         cmd_reg     <= CMD_NOP;
         csel_reg    <= '0;
         ap_reg      <= 1'b0;
         cke_reg     <= 1'b1;
      end else begin
         state_reg   <= state_next;
         wait_reg    <= wait_next;
         sr_mode_reg <= sr_mode_next;
         cmd_reg     <= cmd_next;
         csel_reg    <= csel_next;
         ap_reg      <= ap_next;
         cke_reg     <= cke_next;
      end
   end

   // only SDRAM-private pins are driven by the sequencer
   assign {ras_n, cas_n, we_n} = cmd_reg;
   assign cs_n                 = ~csel_reg;
   assign muxed_address_bit_11 = ap_reg;
   assign cke                  = cke_reg;
   // queued SDRAM accesses wait for the whole sequence
   assign sdram_stall = pend_reg & refresh_enabled | state_reg != ST_IDLE;
   assign mem_owned   = state_reg != ST_IDLE && state_reg != ST_WAIT_BUS
                        && state_reg != ST_LP_BUS;
   assign low_power_done = state_reg == ST_LP_HOLD;
   // ------------------------------------------------------------
   // Address mapping and page size
   // ------------------------------------------------------------
   // linear bank bits; interleaved bank bits
   wire [ADDR_W-1:0] addr_lin = {bus_addr[ADDR_W-1:LBA_MSB+1],
                                 linear_bank_address,
                                 bus_addr[LBA_LSB-1:0]};
   wire [ADDR_W-1:0] addr_il  = {bus_addr[ADDR_W-1:IBA_MSB+1],
                                 interleaved_bank_address,
                                 bus_addr[IBA_LSB-1:0]};
   wire [ADDR_W-1:0] addr_next = interleave_mode ? addr_il : addr_lin;
   // page bytes from column bits and width
   wire [PAGE_W-1:0] col_pow   = PAGE_W'(1) << col_bits;
   wire [PAGE_W-1:0] wbytes    = PAGE_W'(mem_width_bits >> BYTE_SHIFT);
   wire [PAGE_W-1:0] page_next = PAGE_W'(col_pow * wbytes);

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         addr_out  <= '0;
         page_size <= '0;
      end else begin
         addr_out  <= addr_next;
         page_size <= page_next;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   logic [SINCE_W-1:0] since_reg;
   logic [CMD_W-1:0]   last_cmd_reg;
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         since_reg    <= SINCE_MAX;
         last_cmd_reg <= CMD_NOP;
      end else if (cmd_reg != CMD_NOP) begin
         since_reg    <= SINCE_ONE;
         last_cmd_reg <= cmd_reg;
      end else if (since_reg != SINCE_MAX) begin
         since_reg    <= since_reg + SINCE_ONE;
      end
   end
   wire ref_cmd = cmd_reg == CMD_REF && cke_reg;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   sequence s_pre_issued;
      cmd_reg == CMD_PRE && ap_reg;
   endsequence
   sequence s_sr_issued;
      cmd_reg == CMD_REF && state_reg == ST_LP_HOLD;
   endsequence
   a_tick_sets_pend: assert property (tick |=> pend_reg)
      else $error("tick did not set pending");
   a_pre_after_bus: assert property (
      state_reg == ST_PRE |-> !$past(bus_busy))
      else $error("precharge before bus idle");
   a_rp_spacing: assert property (
      ref_cmd && last_cmd_reg == CMD_PRE |-> since_reg > rp_cycles)
      else $error("refresh too soon after precharge");
   a_rc_spacing: assert property (
      ref_cmd && last_cmd_reg == CMD_REF |-> since_reg > rc_cycles)
      else $error("refresh too soon after refresh");
   a_stall_held: assert property (
      mem_owned |-> sdram_stall)
      else $error("access not stalled during refresh");
   a_no_rate_idle: assert property (
      !refresh_enabled && !lp_cond && state_reg == ST_IDLE
      |=> cmd_reg == CMD_NOP)
      else $error("refresh with rate zero");
   a_sr_cke_low: assert property (
      s_pre_issued ##[1:20] s_sr_issued |=> !cke)
      else $error("clock enable not low after self-refresh");
   a_bank_linear: assert property (
      !$past(reset) && !interleave_mode |=>
      addr_out[LBA_MSB:LBA_LSB] == $past(linear_bank_address))
      else $error("linear bank bits wrong");
   a_bank_inter: assert property (
      !$past(reset) && interleave_mode |=>
      addr_out[IBA_MSB:IBA_LSB] == $past(interleaved_bank_address))
      else $error("interleaved bank bits wrong");
   a_upper_row: assert property (
      !$past(reset) |=> addr_out[ADDR_W-1:ROW_HI_LSB]
      == $past(bus_addr[ADDR_W-1:ROW_HI_LSB]))
      else $error("upper row bits altered");
   a_pd_mode: assert property (
      state_reg == ST_LP_ENTER && !sr_mode_reg |=> cmd_reg == CMD_NOP)
      else $error("self-refresh issued with refresh disabled");
endmodule

// ===== sdram_refresh_map_tb.sv
// Self-checking testbench for the SDRAM refresh and bank mapping block
`timescale 1ns/1ns
module sdram_refresh_map_tb
   import sdram_refresh_pkg::*;
;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   localparam logic [3:0] RP = 4'h2;
   localparam logic [3:0] RC = 4'h3;
   logic        mclk, reset, refresh_clk, sys_reset_in, low_power_req;
   logic        bus_busy, rate_wr, rate_sel, interleave_mode;
   logic [1:0]  refresh_rate_field;
   logic [3:0]  rp_cycles, rc_cycles, col_bits, interleaved_bank_address;
   logic [25:0] bus_addr, addr_out;
   logic [4:0]  linear_bank_address;
   logic [5:0]  mem_width_bits;
   logic [19:0] page_size;
   logic        muxed_address_bit_11, ras_n, cas_n, we_n, cke;
   logic [1:0]  cs_n;
   logic        sdram_stall, mem_owned, refresh_enabled, low_power_done;
   int          pre_cnt, sr_cnt, pd_cnt, pre_gap, ref_gap;
   int          ref_cnt [2];
   int          fail_count = 0;
   int          comparisons = 0;

   sdram_refresh_map #(.NUM_CS(2)) u_dut (
      .mclk(mclk), .reset(reset), .refresh_clk(refresh_clk),
      .sys_reset_in(sys_reset_in), .low_power_req(low_power_req),
      .bus_busy(bus_busy), .rate_wr(rate_wr), .rate_sel(rate_sel),
      .refresh_rate_field(refresh_rate_field), .rp_cycles(rp_cycles),
      .rc_cycles(rc_cycles), .interleave_mode(interleave_mode),
      .bus_addr(bus_addr), .linear_bank_address(linear_bank_address),
      .interleaved_bank_address(interleaved_bank_address),
      .col_bits(col_bits), .mem_width_bits(mem_width_bits),
      .addr_out(addr_out), .page_size(page_size),
      .muxed_address_bit_11(muxed_address_bit_11), .ras_n(ras_n),
      .cas_n(cas_n), .we_n(we_n), .cs_n(cs_n), .cke(cke),
      .sdram_stall(sdram_stall), .mem_owned(mem_owned),
      .refresh_enabled(refresh_enabled), .low_power_done(low_power_done));

   sdram_model #(.NUM_CS(2)) u_mem (
      .mclk(mclk), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
      .we_n(we_n), .cke(cke), .precharge_all(muxed_address_bit_11),
      .pre_cnt(pre_cnt), .ref_cnt(ref_cnt),
      .sr_cnt(sr_cnt), .pd_cnt(pd_cnt), .pre_gap(pre_gap),
      .ref_gap(ref_gap));

   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // One 23 ns refresh clock period; it stands still between ticks
   task automatic tick();
      #7;
      refresh_clk = 1'b1;
      #16;
      refresh_clk = 1'b0;
   endtask
   task automatic wait_on(input logic lp, input logic lvl);
      int n;
      n = 0;
      while ((lp ? low_power_done : sdram_stall) !== lvl && n < 400) begin
         @(negedge mclk);
         n++;
      end
      check(lp ? low_power_done : sdram_stall, lvl);
   endtask
   task automatic set_rate(input logic sel, input logic [1:0] code);
      @(posedge mclk);
      rate_wr <= 1'b1;
      rate_sel <= sel;
      refresh_rate_field <= code;
      @(posedge mclk);
      rate_wr <= 1'b0;
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_addr(input logic il, input logic [3:0] col,
                         input logic [5:0] w, input logic [19:0] pg);
      @(posedge mclk);
      interleave_mode <= il;
      bus_addr <= 26'h3abcdef;
      col_bits <= col;
      mem_width_bits <= w;
      repeat (2) @(negedge mclk);
      check(addr_out[25:21], bus_addr[25:21]);
      if (il) begin
         check(addr_out[19:16], 4'ha);
         check(addr_out[15:11], 5'h19);
      end else begin
         check(addr_out[15:11], 5'h15);
         check(addr_out[19:16], 4'hb);
      end
      check(page_size, pg);
   endtask
   task automatic t_refresh(input logic [1:0] r0, r1, input int e0, e1);
      int b0;
      int b1;
      set_rate(1'b0, r0);
      set_rate(1'b1, r1);
      @(negedge mclk);
      check(refresh_enabled, (r0 | r1) != 2'h0);
      b0 = ref_cnt[0];
      b1 = ref_cnt[1];
      tick();
      wait_on(1'b0, 1'b1);
      wait_on(1'b0, 1'b0);
      check(ref_cnt[0] - b0, e0);
      check(ref_cnt[1] - b1, e1);
      check(pre_gap >= RP + 1, 1'b1);
      check(e0 < 2 || ref_gap >= RC + 1, 1'b1);
   endtask
   task automatic t_busy();
      int p;
      p = pre_cnt;
      @(posedge mclk);
      bus_busy <= 1'b1;
      tick();
      repeat (30) @(negedge mclk);
      check(pre_cnt - p, 0);
      check(sdram_stall, 1'b1);
      check(mem_owned, 1'b0);
      @(posedge mclk);
      bus_busy <= 1'b0;
      wait_on(1'b0, 1'b0);
      check(pre_cnt - p, 1);
   endtask
   task automatic t_lowpower(input logic use_sys, input logic en);
      int s;
      int d;
      int p;
      s = sr_cnt;
      d = pd_cnt;
      p = pre_cnt;
      @(posedge mclk);
      sys_reset_in <= use_sys;
      low_power_req <= !use_sys;
      wait_on(1'b1, 1'b1);
      @(negedge mclk);
      check(cke, 1'b0);
      check(pre_cnt > p, 1'b1);
      check(mem_owned, 1'b1);
      // The model logs the clock enable fall one edge after it
      @(negedge mclk);
      check(sr_cnt - s, en);
      check(pd_cnt - d, !en);
      @(posedge mclk);
      sys_reset_in <= 1'b0;
      low_power_req <= 1'b0;
      wait_on(1'b1, 1'b0);
      repeat (10) @(negedge mclk);
      check(cke, 1'b1);
   endtask
   task automatic t_ctrl_reset();
      @(posedge mclk);
      reset <= 1'b1;
      repeat (2) @(posedge mclk);
      reset <= 1'b0;
      @(negedge mclk);
      check(refresh_enabled, 1'b0);
      check(cs_n, 2'h3);
      t_lowpower(1'b1, 1'b0);
   endtask
   // ------------------------------------------------------------
   // Main sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      reset = 1'b1;
      {refresh_clk, sys_reset_in, low_power_req, bus_busy} = 4'h0;
      {rate_wr, rate_sel, interleave_mode} = 3'h0;
      refresh_rate_field = 2'h0;
      rp_cycles = RP;
      rc_cycles = RC;
      bus_addr = 26'h0;
      linear_bank_address = 5'h15;
      interleaved_bank_address = 4'ha;
      col_bits = 4'h8;
      mem_width_bits = 6'h20;
      repeat (16) @(posedge mclk);
      reset <= 1'b0;
      @(negedge mclk);
      check(refresh_enabled, 1'b0);
      check(cke, 1'b1);
      t_addr(1'b0, 4'h9, 6'h20, 20'h00800);
      t_addr(1'b1, 4'h8, 6'h10, 20'h00200);
      t_addr(1'b0, 4'ha, 6'h08, 20'h00400);
      t_refresh(2'h1, 2'h3, 1, 4);
      t_refresh(2'h2, 2'h0, 2, 0);
      t_busy();
      t_lowpower(1'b1, 1'b1);
      t_lowpower(1'b0, 1'b1);
      t_ctrl_reset();
      tally_and_finish();
   end
   // Whole run needs well under 5000 mclk cycles
   initial begin
      #400000;
      fail_count++;
      tally_and_finish();
   end
endmodule

// ===== sdram_refresh_pkg.sv
// Shared constants for the SDRAM refresh and bank address mapping block
package sdram_refresh_pkg;
   // ------------------------------------------------------------
   // Address pin layout
   // ------------------------------------------------------------
   localparam int ADDR_W        = 26;
   localparam int ROW_HI_LSB    = 21;
   localparam int LBA_W         = 5;
   localparam int LBA_LSB       = 11;
   localparam int LBA_MSB       = 15;
   localparam int IBA_W         = 4;
   localparam int IBA_LSB       = 16;
   localparam int IBA_MSB       = 19;
   // ------------------------------------------------------------
   // Page size arithmetic
   // ------------------------------------------------------------
   localparam int PAGE_W        = 20;
   localparam int COL_W         = 4;
   localparam int MWID_W        = 6;
   localparam int BYTE_SHIFT    = 3;
   // ------------------------------------------------------------
   // Commands as {ras_n, cas_n, we_n}
   // ------------------------------------------------------------
   localparam int CMD_W         = 3;
   localparam logic [2:0] CMD_NOP = 3'h7;
   localparam logic [2:0] CMD_PRE = 3'h2;
   localparam logic [2:0] CMD_REF = 3'h1;
   // ------------------------------------------------------------
   // Refresh rate codes and cycles per tick
   // ------------------------------------------------------------
   localparam int RATE_W        = 2;
   localparam int CNT_W         = 3;
   localparam logic [1:0] RATE_OFF  = 2'h0;
   localparam logic [1:0] RATE_ONE  = 2'h1;
   localparam logic [1:0] RATE_TWO  = 2'h2;
   localparam logic [2:0] CNT_ZERO  = 3'h0;
   localparam logic [2:0] CNT_ONE   = 3'h1;
   localparam logic [2:0] CNT_TWO   = 3'h2;
   localparam logic [2:0] CNT_FOUR  = 3'h4;
   // ------------------------------------------------------------
   // Timing counters
   // ------------------------------------------------------------
   localparam int WAIT_W        = 4;
   localparam int SINCE_W       = 5;
   localparam logic [4:0] SINCE_ONE = 5'h01;
   localparam logic [4:0] SINCE_MAX = 5'h1f;
endpackage
